// ---- rc_pkg.sv ----
// Constants for the system reset controller
package rc_pkg;

	// APB geometry
	localparam int          RC_ADDR_W    = 12;
	localparam int          RC_DATA_W    = 32;

	// Register indexes; byte address is four times the index
	localparam logic [RC_ADDR_W-1:0] RC_IDX_CAUSE = 12'h000;
	localparam logic [RC_ADDR_W-1:0] RC_IDX_SOFT_RESET_REQUEST_REG  = 12'h001;
	localparam logic [RC_ADDR_W-1:0] RC_ADDR_CAUSE = RC_IDX_CAUSE << 2;
	localparam logic [RC_ADDR_W-1:0] RC_ADDR_SOFT_RESET_REQUEST_REG  = RC_IDX_SOFT_RESET_REQUEST_REG << 2;

	// Cause flag and trigger bit positions
	localparam int          RC_NUM_SRC   = 6;
	localparam int          RC_BIT_POR   = 0;
	localparam int          RC_BIT_BOD   = 1;
	localparam int          RC_BIT_PIN   = 2;
	localparam int          RC_BIT_WDT   = 3;
	localparam int          RC_BIT_SW    = 4;
	localparam int          RC_BIT_DBG   = 5;
	localparam int          RC_BIT_TRIG  = 0;

	// Reset values
	localparam logic [RC_NUM_SRC-1:0] RC_FLAGS_POR_ONLY = 6'h01;
	localparam logic [RC_DATA_W-1:0]  RC_RDATA_RST      = 32'h0000_0000;

	// Internal initialisation length after all sources release
	localparam int          RC_INIT_CYCLES = 16;
	localparam int          RC_CNT_W       = 4;
	localparam logic [RC_CNT_W-1:0] RC_CNT_LAST = 4'(RC_INIT_CYCLES - 1);
	localparam logic [RC_CNT_W-1:0] RC_CNT_RST  = 4'h0;

	// Sequencer states
	typedef enum logic [1:0] {
		RC_ST_RUN  = 2'b00,
		RC_ST_HOLD = 2'b01,
		RC_ST_INIT = 2'b10,
		RC_ST_LOAD = 2'b11
	} rc_state_t;

endpackage : rc_pkg

// ---- rc_reset_ctrl.sv ----
// System reset controller: source collection, reset sequence, cause flags, APB registers
// Behaviour
// - Six reset request sources are accepted
// - Controller always on; only the pin source gated by an enable; the soft trigger is also gated, by guard_open_i
// - Causing source sets its cause flag
// - After power-on only power-on flag set
// - Flag stays until software writes one
// - Fuse registers reloaded after reset release
// - Power-on clears everything, always enabled
// - Brown-out spares brown-out configuration only
// - Writing trigger bit one requests reset
// - Reset immediate, held until sequence completes
// - Soft, pin, watchdog spare debug and brown-out
// - Pin reset only when fuse enables it
// - Pin low holds reset until high
// - Watchdog time-out issues a reset
// - Debug reset spares debug and brown-out
// - Flag bits five down to zero
// - Power-on clears others; power-on flag software-cleared
// - Trigger bit always reads zero
`timescale 1ns/1ps

module rc_reset_ctrl
	import rc_pkg::*;
(
	// Clock and reset
	input  wire logic                 sys_clk_i,
	input  wire logic                 rstn_i,

	// APB slave
	input  wire logic                 psel_i,
	input  wire logic                 penable_i,
	input  wire logic                 pwrite_i,
	input  wire logic [RC_ADDR_W-1:0] paddr_i,
	input  wire logic [RC_DATA_W-1:0] pwdata_i,
	output logic      [RC_DATA_W-1:0] prdata_o,
	output logic                      pready_o,
	output logic                      pslverr_o,

	// Reset sources
	input  wire logic                 por_det_i,
	input  wire logic                 bod_det_i,
	input  wire logic                 pin_rstn_i,
	input  wire logic                 pin_rst_en_i,
	input  wire logic                 wdt_req_i,
	input  wire logic                 dbg_req_i,
	input  wire logic                 guard_open_i,

	// Reset outputs
	output logic                      sys_rst_o,
	output logic                      dbg_rst_o,
	output logic                      bodcfg_rst_o,
	output logic                      fuse_reload_o,
	output logic      [RC_NUM_SRC-1:0] cause_o
);

	typedef struct packed {
		rc_state_t             st;
		logic [RC_CNT_W-1:0]   cnt;
		logic [1:0]            pin_s;
		logic [1:0]            por_s;
		logic [1:0]            bod_s;
		logic [RC_NUM_SRC-1:0] flags;
		logic                  scope_por;
		logic                  scope_bod;
		logic                  sw_pend;
		logic                  reload;
		logic [RC_DATA_W-1:0]  prdata;
	} rc_regs_t;

	localparam rc_regs_t RC_REGS_RST = '{
		st:        RC_ST_HOLD,
		cnt:       RC_CNT_RST,
		pin_s:     2'h3,
		por_s:     2'h0,
		bod_s:     2'h0,
		flags:     RC_FLAGS_POR_ONLY,
		scope_por: 1'b1,
		scope_bod: 1'b0,
		sw_pend:   1'b0,
		reload:    1'b0,
		prdata:    RC_RDATA_RST
	};

	rc_regs_t q;
	rc_regs_t d;

	function automatic logic rc_hit(input logic [RC_ADDR_W-1:0] a, input logic [RC_ADDR_W-1:0] r);
		rc_hit = (a == r);
	endfunction : rc_hit

	// Decoded bus and source terms
	logic                  acc;
	logic                  wr;
	logic                  mapped;
	logic                  sw_write;
	logic [RC_NUM_SRC-1:0] clr;
	logic                  pin_req;
	logic                  por_req;
	logic                  bod_req;
	logic [RC_NUM_SRC-1:0] src;
	logic                  any_src;
	logic [RC_DATA_W-1:0]  rd_mux;

	always_comb begin
		acc      = psel_i & penable_i;
		wr       = acc & pwrite_i;
		mapped   = rc_hit(paddr_i, RC_ADDR_CAUSE) | rc_hit(paddr_i, RC_ADDR_SOFT_RESET_REQUEST_REG);
		// Trigger only through the unlocked guard window
		sw_write = wr & rc_hit(paddr_i, RC_ADDR_SOFT_RESET_REQUEST_REG) & pwdata_i[RC_BIT_TRIG] & guard_open_i;
		clr      = (wr & rc_hit(paddr_i, RC_ADDR_CAUSE)) ? pwdata_i[RC_NUM_SRC-1:0] : '0;
		pin_req  = pin_rst_en_i & ~q.pin_s[1];
		por_req  = q.por_s[1];
		bod_req  = q.bod_s[1];
		src      = '0;
		src[RC_BIT_POR] = por_req;
		src[RC_BIT_BOD] = bod_req;
		src[RC_BIT_PIN] = pin_req;
		src[RC_BIT_WDT] = wdt_req_i;
		src[RC_BIT_SW]  = q.sw_pend | sw_write;
		src[RC_BIT_DBG] = dbg_req_i;
		any_src  = |src;
		rd_mux   = '0;
		if (rc_hit(paddr_i, RC_ADDR_CAUSE)) begin
			rd_mux[RC_NUM_SRC-1:0] = q.flags;
		end
		// Trigger register has no readable state
		if (rc_hit(paddr_i, RC_ADDR_SOFT_RESET_REQUEST_REG)) begin
			rd_mux = '0;
		end
	end

	always_comb begin
		d = q;

		// Two-stage synchronisers
		d.pin_s = {q.pin_s[0], pin_rstn_i};
		d.por_s = {q.por_s[0], por_det_i};
		d.bod_s = {q.bod_s[0], bod_det_i};

		d.sw_pend = sw_write;
		d.reload  = 1'b0;

		// Read data captured in the setup phase
		if (psel_i & ~penable_i) begin
			d.prdata = rd_mux;
		end

		// Set wins over the software clear
		d.flags = (q.flags & ~clr) | src;
		if (por_req) begin
			d.flags = RC_FLAGS_POR_ONLY;
		end else if (q.scope_por && q.st != RC_ST_RUN) begin
			d.flags = (q.flags & ~clr) | RC_FLAGS_POR_ONLY;
		end

		unique case (q.st)
			RC_ST_RUN: begin
				if (any_src) begin
					d.st        = RC_ST_HOLD;
					d.scope_por = por_req;
					d.scope_bod = bod_req;
				end
			end
			RC_ST_HOLD: begin
				d.scope_por = q.scope_por | por_req;
				d.scope_bod = q.scope_bod | bod_req;
				if (!any_src) begin
					d.st  = RC_ST_INIT;
					d.cnt = RC_CNT_RST;
				end
			end
			RC_ST_INIT: begin
				if (any_src) begin
					d.st        = RC_ST_HOLD;
					d.scope_por = q.scope_por | por_req;
					d.scope_bod = q.scope_bod | bod_req;
				end else if (q.cnt == RC_CNT_LAST) begin
					d.st     = RC_ST_LOAD;
					d.reload = 1'b1;
				end else begin
					d.cnt = q.cnt + 4'h1;
				end
			end
			RC_ST_LOAD: begin
				d.st        = any_src ? RC_ST_HOLD : RC_ST_RUN;
				d.scope_por = any_src & (q.scope_por | por_req);
				d.scope_bod = any_src & (q.scope_bod | bod_req);
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			q <= RC_REGS_RST;
		end else begin
			q <= d;
		end
	end

	// Reset scope: debug kept through all but supply resets
	assign sys_rst_o     = (q.st != RC_ST_RUN);
	assign dbg_rst_o     = sys_rst_o & (q.scope_por | q.scope_bod);
	assign bodcfg_rst_o  = sys_rst_o & q.scope_por;
	assign fuse_reload_o = q.reload;
	assign cause_o       = q.flags;
	assign prdata_o      = q.prdata;
	assign pready_o      = 1'b1;
	assign pslverr_o     = acc & ~mapped;

	default clocking rc_cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rstn_i);

	AST_SW_RESET: assert property (sw_write |=> sys_rst_o && q.flags[RC_BIT_SW])
		else $error("software trigger did not enter reset");

	AST_SW_HELD: assert property (sw_write |=> sys_rst_o [*8])
		else $error("software reset released before sequence end");

	AST_TRIG_READ0: assert property (acc && !pwrite_i && rc_hit(paddr_i, RC_ADDR_SOFT_RESET_REQUEST_REG) |-> prdata_o == '0)
		else $error("trigger register read nonzero");

	AST_POR_FLAGS: assert property (por_req |=> q.flags == RC_FLAGS_POR_ONLY && bodcfg_rst_o)
		else $error("power-on did not leave only its flag");

	AST_FLAG_STICKY: assert property (clr == '0 && !any_src && !(q.scope_por && q.st != RC_ST_RUN)
		|=> q.flags == $past(q.flags))
		else $error("cause flag changed without cause");

	AST_FLAG_CLEAR: assert property (clr[RC_BIT_PIN] && !src[RC_BIT_PIN] && !por_req |=> !q.flags[RC_BIT_PIN])
		else $error("write of one did not clear flag");

	AST_PIN_HOLD: assert property (pin_req |=> sys_rst_o && q.flags[RC_BIT_PIN])
		else $error("pin low did not hold reset");

	AST_PIN_GATED: assert property (!pin_rst_en_i && src[RC_NUM_SRC-1:0] == '0 && q.st == RC_ST_RUN
		|=> !sys_rst_o)
		else $error("reset without an enabled source");

	AST_RELOAD: assert property (q.st == RC_ST_INIT && q.cnt == RC_CNT_LAST && !any_src
		|=> fuse_reload_o ##1 !fuse_reload_o)
		else $error("fuse reload not pulsed at release");

	AST_USER_SCOPE: assert property (q.st == RC_ST_RUN && !por_req && !bod_req && any_src
		|=> sys_rst_o && !dbg_rst_o && !bodcfg_rst_o)
		else $error("user reset reached debug or brown-out config");

	AST_BOD_SCOPE: assert property (q.st == RC_ST_RUN && bod_req && !por_req
		|=> dbg_rst_o && !bodcfg_rst_o && q.flags[RC_BIT_BOD])
		else $error("brown-out reset scope wrong");

	AST_WDT: assert property (wdt_req_i |=> sys_rst_o && q.flags[RC_BIT_WDT])
		else $error("watchdog request ignored");

	AST_DBG: assert property (dbg_req_i && q.st == RC_ST_RUN && !por_req && !bod_req
		|=> sys_rst_o && !dbg_rst_o && q.flags[RC_BIT_DBG])
		else $error("debug reset scope wrong");

	AST_RELEASE: assert property ($fell(sys_rst_o) |-> $past(fuse_reload_o))
		else $error("reset released without completing sequence");

	// Bus answer and error checks
	AST_PREADY: assert property (acc |-> pready_o)
		else $error("register access not answered");

	AST_SLVERR: assert property (acc && !mapped |-> pslverr_o)
		else $error("unmapped access without error");

	AST_NO_SLVERR: assert property (acc && mapped |-> !pslverr_o)
		else $error("mapped access flagged as error");

	AST_UPPER_ZERO: assert property (acc |-> prdata_o[RC_DATA_W-1:RC_NUM_SRC] == '0)
		else $error("unused read bits not zero");

	AST_CAUSE_READ: assert property (acc && !pwrite_i && rc_hit(paddr_i, RC_ADDR_CAUSE) && $past(psel_i && !penable_i)
		|-> prdata_o[RC_NUM_SRC-1:0] == $past(q.flags))
		else $error("cause read does not match flags");

	// Guarded trigger
	AST_TRIG_LOCKED: assert property (q.st == RC_ST_RUN && wr && rc_hit(paddr_i, RC_ADDR_SOFT_RESET_REQUEST_REG) && !guard_open_i
		&& !any_src |=> !sys_rst_o)
		else $error("locked trigger write caused reset");

	// Sequencer progress
	AST_PIN_STAY: assert property (q.st == RC_ST_HOLD && pin_req |=> q.st == RC_ST_HOLD)
		else $error("left hold while pin still low");

	AST_INIT_COUNT: assert property (q.st == RC_ST_INIT && !any_src && q.cnt != RC_CNT_LAST
		|=> q.st == RC_ST_INIT && q.cnt == $past(q.cnt) + 4'h1)
		else $error("initialisation count skipped");

	AST_RESTART: assert property ((q.st == RC_ST_INIT || q.st == RC_ST_LOAD) && any_src
		|=> q.st == RC_ST_HOLD)
		else $error("new request did not restart sequence");

	AST_RELOAD_LOAD: assert property (fuse_reload_o |-> q.st == RC_ST_LOAD)
		else $error("fuse reload outside load step");

	// Flag behaviour
	AST_POR_KEPT: assert property (sys_rst_o && q.scope_por |=> q.flags[RC_BIT_POR])
		else $error("power-on flag lost during power-on reset");

	AST_SET_WINS: assert property (src[RC_BIT_WDT] && clr[RC_BIT_WDT] |=> q.flags[RC_BIT_WDT])
		else $error("clear beat a new watchdog cause");

	AST_BOD_FLAG: assert property (bod_req && !por_req |=> q.flags[RC_BIT_BOD])
		else $error("brown-out cause not recorded");

	// Synchroniser latency
	AST_PIN_SYNC: assert property (!pin_rstn_i ##2 pin_rst_en_i |-> pin_req)
		else $error("pin low not seen after two flops");

	AST_POR_SYNC: assert property (por_det_i |-> ##2 por_req)
		else $error("power-on detect not seen after two flops");

	AST_BOD_SYNC: assert property (bod_det_i |-> ##2 bod_req)
		else $error("brown-out detect not seen after two flops");

	// Scenario coverage
	COV_RESTART: cover property (q.st == RC_ST_INIT && any_src);
	COV_SW_RESET: cover property (sw_write ##[1:40] $fell(sys_rst_o));
	COV_PIN_RESET: cover property (pin_req ##1 !pin_req [*3] ##[1:40] fuse_reload_o);
	COV_POR_SEQ: cover property (por_req ##[1:60] !sys_rst_o);
	COV_FLAG_CLEAR: cover property (clr[RC_BIT_POR] ##1 !q.flags[RC_BIT_POR]);

endmodule : rc_reset_ctrl

// ---- rc_src_model.sv ----
// Model of the reset request sources beside the controller
`timescale 1ns/1ps

module rc_src_model (
	// Clock and commands
	input  wire logic       sys_clk_i,
	input  wire logic [4:0] req_i,

	// Source outputs
	output logic            por_det_o,
	output logic            bod_det_o,
	output logic            pin_rstn_o,
	output logic            wdt_req_o,
	output logic            dbg_req_o
);
	always_ff @(posedge sys_clk_i) begin
		por_det_o  <= req_i[0];
		bod_det_o  <= req_i[1];
		pin_rstn_o <= !req_i[2];
		wdt_req_o  <= req_i[3];
		dbg_req_o  <= req_i[4];
	end
endmodule : rc_src_model

// ---- tb.sv ----
// Self-checking bench for the system reset controller
`timescale 1ns/1ps

module tb;
	import rc_pkg::*;
	logic                  sys_clk_i = 1'b0;
	logic                  rstn_i    = 1'b0;
	logic                  psel_i    = 1'b0;
	logic                  penable_i = 1'b0;
	logic                  pwrite_i  = 1'b0;
	logic [RC_ADDR_W-1:0]  paddr_i   = '0;
	logic [RC_DATA_W-1:0]  pwdata_i  = '0;
	logic [4:0]            req       = 5'h00;
	logic                  pin_en    = 1'b1;
	logic                  guard     = 1'b0;
	logic [RC_DATA_W-1:0]  prdata_o, rd;
	logic                  pready_o, pslverr_o, er, por_d, bod_d, pin_n, wdt_r, dbg_r;
	logic                  sys_rst_o, dbg_rst_o, bodcfg_rst_o, fuse_reload_o;
	logic [RC_NUM_SRC-1:0] cause_o;
	int                    err_count = 0, total_checks = 0, fuse_cnt = 0, n, f;

	initial forever #2 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) if (fuse_reload_o === 1'b1) fuse_cnt <= fuse_cnt + 1;

	rc_src_model src (.sys_clk_i(sys_clk_i), .req_i(req), .por_det_o(por_d), .bod_det_o(bod_d),
		.pin_rstn_o(pin_n), .wdt_req_o(wdt_r), .dbg_req_o(dbg_r));
	rc_reset_ctrl dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .por_det_i(por_d), .bod_det_i(bod_d),
		.pin_rstn_i(pin_n), .pin_rst_en_i(pin_en), .wdt_req_i(wdt_r), .dbg_req_i(dbg_r),
		.guard_open_i(guard), .sys_rst_o(sys_rst_o), .dbg_rst_o(dbg_rst_o),
		.bodcfg_rst_o(bodcfg_rst_o), .fuse_reload_o(fuse_reload_o), .cause_o(cause_o));

	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
		total_checks++;
		if (s !== e) begin
			err_count++;
			$display("BAD %0t %s: %h not %h", $time, m, s, e);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [RC_ADDR_W-1:0] a, input logic [RC_DATA_W-1:0] d);
		@(posedge sys_clk_i);
		psel_i   <= 1'b1;
		pwrite_i <= w;
		paddr_i  <= a;
		pwdata_i <= d;
		@(posedge sys_clk_i);
		penable_i <= 1'b1;
		do @(posedge sys_clk_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		er = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb

	task automatic wait_rst(input logic v);
		n = 0;
		while (sys_rst_o !== v && n < 200) begin
			@(negedge sys_clk_i);
			n++;
		end
		chk(sys_rst_o, v, "reset level");
	endtask : wait_rst

	task automatic src_rst(input int i, input logic [5:0] e, input logic clr);
		if (clr) apb(1'b1, RC_ADDR_CAUSE, 32'h0000_003f);
		@(posedge sys_clk_i);
		req[i] <= 1'b1;
		wait_rst(1'b1);
		repeat (30) @(negedge sys_clk_i);
		chk(sys_rst_o, 1'b1, "held while requested");
		chk(dbg_rst_o, i < 2, "debug reset scope");
		chk(bodcfg_rst_o, i == 0, "brown-out config scope");
		f = fuse_cnt;
		@(posedge sys_clk_i);
		req[i] <= 1'b0;
		wait_rst(1'b0);
		chk(fuse_cnt, f + 1, "fuse reload");
		apb(1'b0, RC_ADDR_CAUSE, '0);
		chk(rd, e, "cause flags");
		chk(cause_o, e, "cause mirror");
		$display("test source %0d done", i);
	endtask : src_rst

	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report

	initial begin
		#80000;
		err_count++;
		final_report();
	end

	initial begin
		repeat (3) @(posedge sys_clk_i);
		rstn_i <= 1'b1;
		@(negedge sys_clk_i);
		chk(cause_o, RC_FLAGS_POR_ONLY, "flags after power-on");
		wait_rst(1'b0);
		chk(fuse_cnt, 1, "reload at release");
		apb(1'b1, RC_ADDR_CAUSE, 32'h0000_0001);
		apb(1'b0, RC_ADDR_CAUSE, '0);
		chk(rd, 32'h0, "power-on flag cleared");
		apb(1'b1, RC_ADDR_SOFT_RESET_REQUEST_REG, 32'h0000_0001);
		repeat (3) @(negedge sys_clk_i);
		chk(sys_rst_o, 1'b0, "locked trigger ignored");
		apb(1'b0, RC_ADDR_SOFT_RESET_REQUEST_REG, '0);
		chk(rd, 32'h0, "trigger reads zero");
		apb(1'b0, 12'h010, '0);
		chk(er, 1'b1, "unmapped address");
		guard <= 1'b1;
		apb(1'b1, RC_ADDR_SOFT_RESET_REQUEST_REG, 32'h0000_0001);
		guard <= 1'b0;
		@(negedge sys_clk_i);
		chk(sys_rst_o, 1'b1, "soft reset immediate");
		chk(dbg_rst_o, 1'b0, "soft reset spares debug");
		wait_rst(1'b0);
		apb(1'b0, RC_ADDR_CAUSE, '0);
		chk(rd, 32'h0000_0010, "soft flag");
		$display("test soft reset done");
		pin_en <= 1'b0;
		req[2] <= 1'b1;
		repeat (10) @(negedge sys_clk_i);
		chk(sys_rst_o, 1'b0, "pin disabled");
		@(posedge sys_clk_i);
		req[2] <= 1'b0;
		repeat (5) @(posedge sys_clk_i);
		pin_en <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		for (int i = 1; i < 5; i++) src_rst(i, (i == 4) ? 6'h20 : 6'(1 << i), 1'b1);
		src_rst(0, RC_FLAGS_POR_ONLY, 1'b0);
		final_report();
	end
endmodule : tb
